// File: rtl/ptp_egress_ts_interrupts.sv
// Per-port egress timestamp registers, ready flags and enables.
`timescale 1ns/1ps
module ptp_egress_ts_interrupts
	import ptp_egress_ts_pkg::*;
#(
	parameter int TIME_W = 32
)(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_sync_time_valid,
	input  wire logic [31:0] i_sync_time,
	input  wire logic        i_req_time_valid,
	input  wire logic [31:0] i_req_time,
	input  wire logic        i_resp_time_valid,
	input  wire logic [31:0] i_resp_time,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic [15:0] i_reg_wdata,
	output logic      [15:0] o_reg_rdata,
	output logic             o_ptp_irq_status,
	output logic             o_ptp_irq_enable
);

	// ==========================================================
	// Elaboration check.
	if (TIME_W != 32) begin : g_width_check
		$error("TIME_W must be 32: timestamps split into two 16-bit words");
	end

	// ==========================================================
	// Captured timestamps.
	logic [31:0] sync_egress_time_q;
	logic [31:0] req_egress_time_q;
	logic [31:0] pdelay_resp_egress_time_q;
	logic [2:0]  irq_en_q;
	logic [2:0]  irq_en_d;
	logic [2:0]  flags;
	logic [2:0]  flags_d;
	logic [2:0]  events;
	logic        flag_wr;

	// Latest Sync time; a new capture simply overwrites the old one.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			sync_egress_time_q <= TIME_RESET;
		end else if (i_sync_time_valid) begin
			sync_egress_time_q <= i_sync_time;
		end
	end

	// Latest request time.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			req_egress_time_q <= TIME_RESET;
		end else if (i_req_time_valid) begin
			req_egress_time_q <= i_req_time;
		end
	end

	// Latest Pdelay_Resp time, both halves together.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pdelay_resp_egress_time_q <= TIME_RESET;
		end else if (i_resp_time_valid) begin
			pdelay_resp_egress_time_q <= i_resp_time;
		end
	end

	// ==========================================================
	// Ready flags, index 2 = Sync, 1 = request, 0 = Pdelay_Resp.
	assign events  = {i_sync_time_valid, i_req_time_valid,
	                  i_resp_time_valid};
	assign flag_wr = i_reg_wr && (i_reg_addr == OFF_IRQ_FLAGS);

	// One sticky cell per frame class; write data bits map by position.
	for (genvar k = 0; k < 3; k++) begin : g_flag
		ptp_sticky_flag u_flag (
			.i_ref_clk (i_ref_clk),
			.i_rst     (i_rst),
			.i_set     (events[k]),
			.i_clear   (flag_wr && i_reg_wdata[BIT_RESP + k]),
			.o_flag    (flags[k]),
			.o_flag_d  (flags_d[k])
		);
	end

	// ==========================================================
	// Enables; only bits 15 to 13 are stored.
	always_comb begin
		irq_en_d = irq_en_q;
		if (i_reg_wr && (i_reg_addr == OFF_IRQ_ENABLES)) begin
			irq_en_d = i_reg_wdata[BIT_SYNC:BIT_RESP];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			irq_en_q <= EVENT_RESET;
		end else begin
			irq_en_q <= irq_en_d;
		end
	end

	// Aggregates use next values so the outputs track the bits
	// with no extra cycle while still coming from flip-flops.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_ptp_irq_status <= 1'b0;
			o_ptp_irq_enable <= 1'b0;
		end else begin
			o_ptp_irq_status <= |flags_d;
			o_ptp_irq_enable <= |irq_en_d;
		end
	end

	// ==========================================================
	// Read data, registered: the word for i_reg_addr appears one
	// cycle later. Unmapped offsets read zero.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_reg_rdata <= REG_RESET;
		end else begin
			case (i_reg_addr)
				OFF_REQ_TIME_HI:  o_reg_rdata <= req_egress_time_q[31:16];
				OFF_REQ_TIME_LO:  o_reg_rdata <= req_egress_time_q[15:0];
				OFF_SYNC_TIME_HI: o_reg_rdata <= sync_egress_time_q[31:16];
				OFF_SYNC_TIME_LO: o_reg_rdata <= sync_egress_time_q[15:0];
				OFF_RESP_TIME_HI: begin
					o_reg_rdata <= pdelay_resp_egress_time_q[31:16];
				end
				OFF_RESP_TIME_LO: begin
					o_reg_rdata <= pdelay_resp_egress_time_q[15:0];
				end
				OFF_IRQ_FLAGS:    o_reg_rdata <= {flags, 13'h0000};
				OFF_IRQ_ENABLES:  o_reg_rdata <= {irq_en_q, 13'h0000};
				default:          o_reg_rdata <= REG_RESET;
			endcase
		end
	end

	// ==========================================================
	// Checks.
	resp_low_read_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_resp_time_valid ##1 (i_reg_addr == OFF_RESP_TIME_LO))
		|=> o_reg_rdata == $past(i_resp_time[15:0], 2))
		else $error("Pdelay_Resp low word not read back");

	sync_flag_set_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_sync_time_valid |=> (flags[2] && o_ptp_irq_status))
		else $error("Sync ready flag not set");

	w1c_zero_keeps_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(flags[2] && flag_wr && !i_reg_wdata[BIT_SYNC]) |=> flags[2])
		else $error("Writing zero cleared the Sync flag");

	req_flag_set_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_req_time_valid && flag_wr) |=> flags[1])
		else $error("Request flag lost on clear collision");

	resp_flag_clear_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(flag_wr && i_reg_wdata[BIT_RESP] && !i_resp_time_valid)
		|=> !flags[0])
		else $error("Pdelay_Resp flag not cleared by one");

	status_or_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		o_ptp_irq_status == (|flags))
		else $error("PTP status output differs from flag OR");

	enable_write_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_reg_wr && i_reg_addr == OFF_IRQ_ENABLES)
		|=> irq_en_q == $past(i_reg_wdata[15:13]))
		else $error("Enable bits did not take write data");

	enable_or_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		o_ptp_irq_enable == (|irq_en_q))
		else $error("PTP enable output differs from enable OR");

	flags_reset_a: assert property (
		@(posedge i_ref_clk)
		i_rst |=> (flags == 3'h0 && irq_en_q == 3'h0 && !o_ptp_irq_status))
		else $error("Flags or enables not cleared by reset");

	resp_high_read_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_reg_addr == OFF_RESP_TIME_HI)
		|=> o_reg_rdata == $past(pdelay_resp_egress_time_q[31:16]))
		else $error("Pdelay_Resp high word wrong");

	sync_words_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_sync_time_valid ##1 (i_reg_addr == OFF_SYNC_TIME_HI))
		|=> o_reg_rdata == $past(i_sync_time[31:16], 2))
		else $error("Sync high word not read back");

	reserved_zero_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_reg_addr == OFF_IRQ_FLAGS || i_reg_addr == OFF_IRQ_ENABLES)
		|=> o_reg_rdata[12:0] == 13'h0000)
		else $error("Reserved bits read nonzero");

endmodule

// File: rtl/ptp_egress_ts_pkg.sv
// Package: register offsets, field positions and reset values.
package ptp_egress_ts_pkg;

	// ==========================================================
	// Register byte offsets inside the port's PTP block.
	localparam logic [7:0] OFF_REQ_TIME_HI  = 8'h08;
	localparam logic [7:0] OFF_REQ_TIME_LO  = 8'h0A;
	localparam logic [7:0] OFF_SYNC_TIME_HI = 8'h0C;
	localparam logic [7:0] OFF_SYNC_TIME_LO = 8'h0E;
	localparam logic [7:0] OFF_RESP_TIME_HI = 8'h10;
	localparam logic [7:0] OFF_RESP_TIME_LO = 8'h12;
	localparam logic [7:0] OFF_IRQ_FLAGS    = 8'h14;
	localparam logic [7:0] OFF_IRQ_ENABLES  = 8'h16;

	// ==========================================================
	// Bit positions shared by the flag and enable registers.
	localparam int BIT_SYNC = 15;
	localparam int BIT_REQ  = 14;
	localparam int BIT_RESP = 13;

	// ==========================================================
	// Values after reset.
	localparam logic [15:0] REG_RESET    = 16'h0000;
	localparam logic [31:0] TIME_RESET   = 32'h0000_0000;
	localparam logic [2:0]  EVENT_RESET  = 3'h0;

endpackage

// File: rtl/ptp_sticky_flag.sv
// Sticky event flag, set by hardware and cleared by writing a one.
`timescale 1ns/1ps
module ptp_sticky_flag
	import ptp_egress_ts_pkg::*;
(
	input  wire logic i_ref_clk,
	input  wire logic i_rst,
	input  wire logic i_set,
	input  wire logic i_clear,
	output logic      o_flag,
	output logic      o_flag_d
);

	// Set beats clear so an event landing on the clear cycle survives.
	always_comb begin
		if (i_set) begin
			o_flag_d = 1'b1;
		end else if (i_clear) begin
			o_flag_d = 1'b0;
		end else begin
			o_flag_d = o_flag;
		end
	end

	// Flag storage, empty after reset.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_flag <= EVENT_RESET[0];
		end else begin
			o_flag <= o_flag_d;
		end
	end

endmodule

// File: tb/tb_top.sv
// Self-checking bench for the per-port egress timestamp flag block.
`timescale 1ns/1ps
module tb_top;
	import ptp_egress_ts_pkg::*;

	// ==========================================================
	// Stimulus signals; after the blocking initial values, all DUT inputs but the clock are driven by non-blocking assignment.
	logic        i_ref_clk;
	logic        i_rst;
	logic        i_sync_time_valid;
	logic [31:0] i_sync_time;
	logic        i_req_time_valid;
	logic [31:0] i_req_time;
	logic        i_resp_time_valid;
	logic [31:0] i_resp_time;
	logic [7:0]  i_reg_addr;
	logic        i_reg_wr;
	logic [15:0] i_reg_wdata;
	logic [15:0] o_reg_rdata;
	logic        o_ptp_irq_status;
	logic        o_ptp_irq_enable;
	int          n_errors;
	int          samples_checked;
	logic [7:0]  hi_off [3];
	int          bit_pos [3];
	logic [31:0] tv;

	ptp_egress_ts_interrupts #(.TIME_W(32)) u_ptp_egress_ts_interrupts (
		.i_ref_clk        (i_ref_clk),
		.i_rst            (i_rst),
		.i_sync_time_valid(i_sync_time_valid),
		.i_sync_time      (i_sync_time),
		.i_req_time_valid (i_req_time_valid),
		.i_req_time       (i_req_time),
		.i_resp_time_valid(i_resp_time_valid),
		.i_resp_time      (i_resp_time),
		.i_reg_addr       (i_reg_addr),
		.i_reg_wr         (i_reg_wr),
		.i_reg_wdata      (i_reg_wdata),
		.o_reg_rdata      (o_reg_rdata),
		.o_ptp_irq_status (o_ptp_irq_status),
		.o_ptp_irq_enable (o_ptp_irq_enable)
	);

	// 20 MHz clock.
	always #25 i_ref_clk = ~i_ref_clk;

	// ==========================================================
	// Shared tasks for compares and register cycles.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Read data answers exactly one edge after the address is taken.
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge i_ref_clk);
		i_reg_addr <= a;
		@(posedge i_ref_clk);
		@(negedge i_ref_clk);
		check(o_reg_rdata, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_ref_clk);
		i_reg_addr  <= a;
		i_reg_wdata <= d;
		i_reg_wr    <= 1'b1;
		@(posedge i_ref_clk);
		i_reg_wr    <= 1'b0;
	endtask

	// One-cycle capture pulse for class k: 0 Sync, 1 request, 2 response.
	task automatic ev(input int k, input logic [31:0] t);
		@(posedge i_ref_clk);
		i_sync_time_valid <= (k == 0);
		i_req_time_valid  <= (k == 1);
		i_resp_time_valid <= (k == 2);
		if (k == 0) i_sync_time <= t;
		if (k == 1) i_req_time <= t;
		if (k == 2) i_resp_time <= t;
		@(posedge i_ref_clk);
		{i_sync_time_valid, i_req_time_valid, i_resp_time_valid} <= 3'h0;
	endtask

	// The run ends here only, from the tests or from the watchdog.
	task automatic print_verdict();
		$display("Counts: %0d compared, %0d mismatched", samples_checked,
			n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// Watchdog at 3000 cycles, far beyond the roughly 135 cycles the tests need.
	initial begin
		#(50 * 3000);
		n_errors++;
		print_verdict();
	end

	// ==========================================================
	// Test sequence.
	initial begin
		{i_ref_clk, i_reg_wr, i_reg_addr, i_reg_wdata} = '0;
		{i_sync_time_valid, i_req_time_valid, i_resp_time_valid} = 3'h0;
		{i_sync_time, i_req_time, i_resp_time} = '0;
		i_rst = 1'b1;
		n_errors = 0;
		samples_checked = 0;
		hi_off = '{OFF_SYNC_TIME_HI, OFF_REQ_TIME_HI, OFF_RESP_TIME_HI};
		bit_pos = '{BIT_SYNC, BIT_REQ, BIT_RESP};
		repeat (5) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		// Every mapped offset reads its reset value; an unmapped one reads 0.
		for (int a = 8'h08; a <= 8'h16; a += 2) rd(8'(a), REG_RESET);
		rd(8'h20, 16'h0000);
		check({15'h0, o_ptp_irq_enable}, 16'h0000);
		$display("Test reset values done");
		// Reserved enable bits drop, then each enable alone drives the OR.
		wr(OFF_IRQ_ENABLES, 16'hFFFF);
		rd(OFF_IRQ_ENABLES, 16'hE000);
		for (int k = 0; k < 3; k++) begin
			wr(OFF_IRQ_ENABLES, 16'h0001 << bit_pos[k]);
			rd(OFF_IRQ_ENABLES, 16'h0001 << bit_pos[k]);
			check({15'h0, o_ptp_irq_enable}, 16'h0001);
		end
		wr(OFF_IRQ_ENABLES, 16'h1FFF);
		// The enable output changes on the write edge, so look half a cycle on.
		@(negedge i_ref_clk);
		check({15'h0, o_ptp_irq_enable}, 16'h0000);
		$display("Test enables done");
		// Each class latches its time and raises only its own flag.
		for (int k = 0; k < 3; k++) begin
			tv = 32'h8421_1248 + 32'(k) * 32'h0101_0101;
			ev(k, tv);
			@(negedge i_ref_clk);
			check({15'h0, o_ptp_irq_status}, 16'h0001);
			rd(OFF_IRQ_FLAGS, 16'h0001 << bit_pos[k]);
			rd(hi_off[k], tv[31:16]);
			rd(hi_off[k] + 8'h02, tv[15:0]);
			wr(hi_off[k], 16'h5A5A);
			rd(hi_off[k], tv[31:16]);
			wr(OFF_IRQ_FLAGS, ~(16'h0001 << bit_pos[k]));
			rd(OFF_IRQ_FLAGS, 16'h0001 << bit_pos[k]);
			wr(OFF_IRQ_FLAGS, 16'h0001 << bit_pos[k]);
			rd(OFF_IRQ_FLAGS, 16'h0000);
			check({15'h0, o_ptp_irq_status}, 16'h0000);
		end
		$display("Test flags and times done");
		// A request capture meets a clear of its own bit: the set must win.
		// A Sync capture in the same cycle is read back at once.
		@(posedge i_ref_clk);
		i_req_time_valid  <= 1'b1;
		i_sync_time_valid <= 1'b1;
		i_sync_time       <= 32'hC3A5_0F96;
		i_reg_addr        <= OFF_IRQ_FLAGS;
		i_reg_wdata       <= 16'h4000;
		i_reg_wr          <= 1'b1;
		@(posedge i_ref_clk);
		i_req_time_valid  <= 1'b0;
		i_sync_time_valid <= 1'b0;
		i_reg_wr          <= 1'b0;
		i_reg_addr        <= OFF_SYNC_TIME_HI;
		@(posedge i_ref_clk);
		@(negedge i_ref_clk);
		check(o_reg_rdata, 16'hC3A5);
		rd(OFF_IRQ_FLAGS, 16'hC000);
		check({15'h0, o_ptp_irq_status}, 16'h0001);
		$display("Test set and clear collision done");
		// Captures of all classes, two cycles apart; OR holds until the last clear.
		ev(0, 32'h0000_0001);
		ev(1, 32'h0000_0002);
		ev(2, 32'hFFFF_FFFF);
		rd(OFF_IRQ_FLAGS, 16'hE000);
		rd(OFF_RESP_TIME_LO, 16'hFFFF);
		wr(OFF_IRQ_FLAGS, 16'hC000);
		@(negedge i_ref_clk);
		check({15'h0, o_ptp_irq_status}, 16'h0001);
		wr(OFF_IRQ_FLAGS, 16'h2000);
		@(negedge i_ref_clk);
		check({15'h0, o_ptp_irq_status}, 16'h0000);
		$display("Test combined flags done");
		// A response capture read back in the very next cycle.
		@(posedge i_ref_clk);
		i_resp_time_valid <= 1'b1;
		i_resp_time       <= 32'h1357_9BDF;
		@(posedge i_ref_clk);
		i_resp_time_valid <= 1'b0;
		i_reg_addr        <= OFF_RESP_TIME_LO;
		@(posedge i_ref_clk);
		@(negedge i_ref_clk);
		check(o_reg_rdata, 16'h9BDF);
		// A reset in mid-run clears a set flag, the enables and the times.
		wr(OFF_IRQ_ENABLES, 16'hE000);
		@(posedge i_ref_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		rd(OFF_IRQ_FLAGS, REG_RESET);
		rd(OFF_IRQ_ENABLES, REG_RESET);
		rd(OFF_RESP_TIME_LO, REG_RESET);
		check({14'h0, o_ptp_irq_status, o_ptp_irq_enable}, 16'h0000);
		$display("Test mid-run reset done");
		print_verdict();
	end
endmodule
